// [core/vdci_pkg.sv]
// Package: register map, field layout and event-selection types for the client event block
package vdci_pkg;

  localparam logic [7:0]  FLAGS_OFFSET    = 8'h78;
  localparam logic [7:0]  ENABLE_OFFSET   = 8'h7c;
  localparam logic [31:0] FLAGS_RESET     = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET    = 32'h0000_0000;

  localparam int BIT_GRAPHICS_PLANE1 = 31;
  localparam int BIT_COMP_WRITEBACK  = 30;
  localparam int BIT_SCALER_OUTPUT   = 29;
  localparam int BIT_SCALER_LUMA_IN  = 20;
  localparam int BIT_SCALER_CHROMA_IN = 19;
  localparam int BIT_PIP_WRITEBACK   = 18;
  localparam int BIT_DEINT_SCALER_OUT = 17;
  localparam int BIT_MOTION_VEC_OUT  = 15;
  localparam int BIT_MOTION_VEC_IN   = 12;
  localparam int BIT_FIELD3_CHROMA   = 5;
  localparam int BIT_FIELD3_LUMA     = 4;
  localparam int BIT_FIELD2_CHROMA   = 3;
  localparam int BIT_FIELD2_LUMA     = 2;
  localparam int BIT_FIELD1_LUMA     = 1;
  localparam int BIT_FIELD1_CHROMA   = 0;

  // Implemented bits of both registers; all others read as zero
  localparam logic [31:0] IMPL_MASK = 32'hE01E_903F;
  // Clients whose default event is end-of-frame received from the sender
  localparam logic [31:0] RX_DEFAULT_MASK = 32'h2002_8000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

  // Per-client event lines from the descriptor logic
  typedef struct packed {
    logic [31:0] desc_valid;   // Descriptor configured for this client
    logic [31:0] desc_event;   // Event chosen by the last descriptor reached
    logic [31:0] eof_sent;     // End of frame sent to receiving module
    logic [31:0] eof_recv;     // End of frame received from transmitting module
  } vdci_events_type;

endpackage

// [core/vdci_client_irq.sv]
// Client group 0 event flags, enables and interrupt line 0 with an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

module vdci_client_irq
  import vdci_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire vdci_pkg::vdci_events_type client_events,
  output logic                           dma_irq_line_zero
);
  import vdci_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [31:0] flags_q;
  logic [31:0] enable_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] event_hit;
  logic [31:0] clear_req;
  logic        addr_ok;
  logic [31:0] rd_word;

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input logic [31:0] fl,
                                           input logic [31:0] en);
    if (a == FLAGS_OFFSET) begin
      return fl & IMPL_MASK;
    end else if (a == ENABLE_OFFSET) begin
      return en & IMPL_MASK;
    end
    return 32'h0000_0000;
  endfunction

  // Bus page decode: only the lowest 256 bytes hold registers
  function automatic logic in_page(input logic [31:0] a);
    return a[31:8] == 24'h00_0000;
  endfunction

  // Data-phase write strobe for one register offset
  function automatic logic wr_hit(input logic       pend,
                                  input logic [7:0] a,
                                  input logic [7:0] off);
    return pend && a == off;
  endfunction

  assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
  assign rd_word = reg_read(haddr[7:0], flags_q, enable_q);

  // Write address is held for the data phase; reads resolve in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite && in_page(haddr);
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite && in_page(haddr)) begin
      hrdata <= rd_word;
    end else if (addr_ok) begin
      hrdata <= 32'h0000_0000;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event selection

  // Descriptor choice wins; else each client falls back to its default EOF side
  assign event_hit = IMPL_MASK & (
      (client_events.desc_valid & client_events.desc_event)
    | (~client_events.desc_valid & RX_DEFAULT_MASK
        & client_events.eof_recv)
    | (~client_events.desc_valid & ~RX_DEFAULT_MASK
        & client_events.eof_sent));

  assign clear_req = wr_hit(wr_pend_q, wr_addr_q, FLAGS_OFFSET) ?
                     (hwdata & IMPL_MASK) : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Flag register, one generate slice per bit; enable register in a single block

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flags_q[gi] <= FLAGS_RESET[gi];
        end else if (event_hit[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (clear_req[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= ENABLE_RESET;
    end else if (wr_hit(wr_pend_q, wr_addr_q, ENABLE_OFFSET)) begin
      enable_q <= hwdata & IMPL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line zero

  logic [31:0] flags_d;
  logic [31:0] enable_d;

  always_comb begin
    flags_d = flags_q;
    for (int i = 0; i < 32; i++) begin
      if (event_hit[i]) begin
        flags_d[i] = 1'b1;
      end else if (clear_req[i]) begin
        flags_d[i] = 1'b0;
      end
    end
    enable_d = wr_hit(wr_pend_q, wr_addr_q, ENABLE_OFFSET) ? (hwdata & IMPL_MASK) : enable_q;
  end

  // Registered so the line follows the registers in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_irq_line_zero <= 1'b0;
    end else begin
      dma_irq_line_zero <= |(flags_d & enable_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    event_hit[BIT_MOTION_VEC_OUT] |=> flags_q[BIT_MOTION_VEC_OUT])
    else $error("flag did not set on event");

  mvout_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !client_events.desc_valid[BIT_MOTION_VEC_OUT] && client_events.eof_recv[BIT_MOTION_VEC_OUT]
    |=> flags_q[BIT_MOTION_VEC_OUT])
    else $error("motion vector out default event lost");

  mvin_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !client_events.desc_valid[BIT_MOTION_VEC_IN] && client_events.eof_sent[BIT_MOTION_VEC_IN]
    |=> flags_q[BIT_MOTION_VEC_IN])
    else $error("motion vector in default event lost");

  flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(flags_q[BIT_FIELD1_LUMA]) |-> $past(clear_req[BIT_FIELD1_LUMA]))
    else $error("flag dropped without a clear");

  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clear_req[BIT_FIELD3_CHROMA] && !event_hit[BIT_FIELD3_CHROMA]
    |=> !flags_q[BIT_FIELD3_CHROMA])
    else $error("write one did not clear flag");

  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dma_irq_line_zero == |(flags_q & enable_q))
    else $error("interrupt level mismatch");

  irq_masked_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable_q == 32'h0000_0000) [*2] |-> !dma_irq_line_zero)
    else $error("interrupt raised with all enables clear");

  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ((flags_q | enable_q) & ~IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit set");

  enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_hit(wr_pend_q, wr_addr_q, ENABLE_OFFSET) |=> enable_q == ($past(hwdata) & IMPL_MASK))
    else $error("enable write not stored");

  enable_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_hit(wr_pend_q, wr_addr_q, ENABLE_OFFSET) |=> $stable(enable_q))
    else $error("enable changed without a write");

  // Bus read path
  read_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && in_page(haddr) && haddr[7:0] == FLAGS_OFFSET
    |=> hrdata == $past(flags_q))
    else $error("flag read returned wrong data");

  read_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && in_page(haddr) && haddr[7:0] == ENABLE_OFFSET
    |=> hrdata == $past(enable_q))
    else $error("enable read returned wrong data");

  read_unmapped_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] != FLAGS_OFFSET && haddr[7:0] != ENABLE_OFFSET
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  read_stands_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !addr_ok |=> $stable(hrdata))
    else $error("read data changed without a transfer");

  ////////////////////////////////////////////////////////////////////////////
  // Per-client checks

  // Client positions in both registers, highest bit first
  localparam int N_CLIENTS = 15;
  localparam int CLIENT_BIT [N_CLIENTS] = '{
    BIT_GRAPHICS_PLANE1, BIT_COMP_WRITEBACK, BIT_SCALER_OUTPUT,
    BIT_SCALER_LUMA_IN, BIT_SCALER_CHROMA_IN, BIT_PIP_WRITEBACK,
    BIT_DEINT_SCALER_OUT, BIT_MOTION_VEC_OUT, BIT_MOTION_VEC_IN,
    BIT_FIELD3_CHROMA, BIT_FIELD3_LUMA,
    BIT_FIELD2_CHROMA, BIT_FIELD2_LUMA,
    BIT_FIELD1_LUMA, BIT_FIELD1_CHROMA
  };

  genvar ci;
  generate
    for (ci = 0; ci < N_CLIENTS; ci++) begin : g_client
      localparam int BP = CLIENT_BIT[ci];

      flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        flags_q[BP] && !clear_req[BP] |=> flags_q[BP])
        else $error("flag dropped without a clear");

      flag_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(flags_q[BP]) |-> $past(event_hit[BP]))
        else $error("flag rose without an event");

      desc_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        client_events.desc_valid[BP] && client_events.desc_event[BP] |=> flags_q[BP])
        else $error("descriptor event did not set flag");

      desc_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !flags_q[BP] && client_events.desc_valid[BP] && !client_events.desc_event[BP]
        |=> !flags_q[BP])
        else $error("flag set without its descriptor event");

      default_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !client_events.desc_valid[BP]
        && (RX_DEFAULT_MASK[BP] ? client_events.eof_recv[BP] : client_events.eof_sent[BP])
        |=> flags_q[BP])
        else $error("default end-of-frame event lost");

      wrong_side_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !flags_q[BP] && !client_events.desc_valid[BP]
        && !(RX_DEFAULT_MASK[BP] ? client_events.eof_recv[BP] : client_events.eof_sent[BP])
        |=> !flags_q[BP])
        else $error("flag set by the other end-of-frame side");

      clear_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_hit(wr_pend_q, wr_addr_q, FLAGS_OFFSET) && hwdata[BP] && !event_hit[BP]
        |=> !flags_q[BP])
        else $error("write one did not clear client flag");

      irq_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        flags_q[BP] && enable_q[BP] |-> dma_irq_line_zero)
        else $error("enabled flag not on interrupt line");
    end
  endgenerate

endmodule

`default_nettype wire

// [verif/vdci_client_model.sv]
// Client-side model driving descriptor and end-of-frame event lines
`timescale 1ns/1ps
`default_nettype none
module vdci_client_model
  import vdci_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic [31:0]          desc_cfg,
  input  wire logic [1:0]           kind,
  input  wire logic [31:0]          bits,
  output vdci_pkg::vdci_events_type ev
);
  // Kind 1 sent, 2 received, 3 descriptor event; pulses last one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev <= '0;
    end else begin
      ev.desc_valid <= desc_cfg;
      ev.desc_event <= (kind == 2'd3) ? bits : '0;
      ev.eof_sent   <= (kind == 2'd1) ? bits : '0;
      ev.eof_recv   <= (kind == 2'd2) ? bits : '0;
    end
  end
endmodule
`default_nettype wire

// [verif/vdci_client_irq_bench.sv]
// Bench for client group 0 flags, enables and interrupt line
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module vdci_client_irq_bench;
  import vdci_pkg::*;
  localparam logic [31:0] FA = 32'h0000_0078;
  localparam logic [31:0] EA = 32'h0000_007c;
  logic            hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, r;
  logic [31:0]     haddr = '0, hwdata = '0, hrdata, desc_cfg = '0, bits = '0, rd, b;
  logic [1:0]      htrans = '0, kind = '0;
  logic [2:0]      hsize = HSIZE_WORD;
  vdci_events_type ev;
  int              failures = 0, n_compared = 0;
  int              pos [15] = '{31, 30, 29, 20, 19, 18, 17, 15, 12, 5, 4, 3, 2, 1, 0};
  always #2.5 hclk = ~hclk;
  vdci_client_irq dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .client_events(ev),
    .dma_irq_line_zero(irq));
  vdci_client_model model_u (.hclk(hclk), .hresetn(hresetn), .desc_cfg(desc_cfg),
    .kind(kind), .bits(bits), .ev(ev));
  task automatic conclude();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask
  // Called just after an edge; returns at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, '0);
    `CHK(nm, e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic fire(input logic [1:0] k, input logic [31:0] v);
    kind <= k;
    bits <= v;
    @(posedge hclk);
    kind <= 2'd0;
    repeat (3) @(posedge hclk);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reg("flags_rst", FA, 32'h0000_0000);
    chk_reg("en_rst", EA, 32'h0000_0000);
    xfer(1'b1, EA, 32'hffff_ffff);
    chk_reg("en_rw", EA, 32'he01e_903f);
    xfer(1'b1, 32'h0000_0040, 32'hffff_ffff);
    chk_reg("unmapped", 32'h0000_0040, 32'h0000_0000);
    fire(2'd1, 32'hffff_ffff);
    chk_reg("sent_all", FA, 32'hc01c_103f);
    `CHK("irq_all", 1'b1, irq)
    xfer(1'b1, FA, 32'h0000_0000);
    chk_reg("keep", FA, 32'hc01c_103f);
    xfer(1'b1, FA, 32'hffff_ffff);
    @(posedge hclk);
    `CHK("irq_off", 1'b0, irq)
    chk_reg("clear", FA, 32'h0000_0000);
    desc_cfg <= 32'hffff_ffff;
    fire(2'd1, 32'hffff_ffff);
    chk_reg("desc_gate", FA, 32'h0000_0000);
    fire(2'd3, 32'h0000_9000);
    chk_reg("desc_evt", FA, 32'h0000_9000);
    xfer(1'b1, FA, 32'hffff_ffff);
    desc_cfg <= '0;
    for (int i = 0; i < 15; i++) begin
      b = 32'h0000_0001 << pos[i];
      r = pos[i] inside {29, 17, 15};
      xfer(1'b1, EA, b);
      fire(r ? 2'd1 : 2'd2, b);
      `CHK("wrong_src", 1'b0, irq)
      fire(r ? 2'd2 : 2'd1, b);
      chk_reg("bit_flag", FA, b);
      `CHK("irq_on", 1'b1, irq)
      xfer(1'b1, EA, 32'h0000_0000);
      @(posedge hclk);
      `CHK("irq_masked", 1'b0, irq)
      xfer(1'b1, FA, b);
    end
    xfer(1'b1, EA, 32'hffff_ffff);
    fire(2'd1, 32'hffff_ffff);
    `CHK("irq_pre", 1'b1, irq)
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("irq_rst", 1'b0, irq)
    chk_reg("flags_rst2", FA, 32'h0000_0000);
    chk_reg("en_rst2", EA, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
